// ===== verilog/flagged_fifo.sv
// Notes on behaviour
// - output ready high only while data held
// - reset drops output ready on third read edge
// - output ready rises third read edge after write
// - output ready falls on the same read edge as the last read
// - first word appears by itself, enables ignored
// - later words advance only with all enables high
// - read clock paces all read side activity
// - reset clears pointers, flags low, almost flag high
// - strobe low at reset uses stored offset
// - strobe high at reset uses offset 256
// - word stored only with ready and both enables
// - write clock paces all write side activity
// - offset capture ignores the write enables
// - offset comes from nine low data bits
// - half full flag at 512 words or more
// - almost flag near empty or near full
// - input ready low when full, back after read
// - data bus released when output enable low
`timescale 1ns/1ps
`default_nettype none
`include "fifo_consts.svh"

module flagged_fifo
	import fifo_pkg::*;
(
	input  wire logic                   clock_in,
	input  wire logic                   rst_n_in,
	input  wire logic                   fifo_reset_n_in,
	input  wire logic                   define_offset_strobe_in,
	input  wire logic                   write_side_clock_in,
	input  wire logic                   write_enable_a_in,
	input  wire logic                   write_enable_b_in,
	input  wire logic [`DATA_W-1:0]     write_data_bus_in,
	input  wire logic                   read_side_clock_in,
	input  wire logic                   read_enable_a_in,
	input  wire logic                   read_enable_b_in,
	input  wire logic                   output_drive_enable_in,
	output logic      [`DATA_W-1:0]     read_data_bus_out,
	output logic                        read_data_bus_oe_out,
	output logic                        output_ready_out,
	output logic                        input_ready_out,
	output logic                        half_full_flag_out,
	output logic                        almost_boundary_flag_out,
	input  wire logic [`AXI_ADDR_W-1:0] s_axi_awaddr_in,
	input  wire logic                   s_axi_awvalid_in,
	output logic                        s_axi_awready_out,
	input  wire logic [31:0]            s_axi_wdata_in,
	input  wire logic [3:0]             s_axi_wstrb_in,
	input  wire logic                   s_axi_wvalid_in,
	output logic                        s_axi_wready_out,
	output logic      [1:0]             s_axi_bresp_out,
	output logic                        s_axi_bvalid_out,
	input  wire logic                   s_axi_bready_in,
	input  wire logic [`AXI_ADDR_W-1:0] s_axi_araddr_in,
	input  wire logic                   s_axi_arvalid_in,
	output logic                        s_axi_arready_out,
	output logic      [31:0]            s_axi_rdata_out,
	output logic      [1:0]             s_axi_rresp_out,
	output logic                        s_axi_rvalid_out,
	input  wire logic                   s_axi_rready_in
);
	function automatic logic reg_hit(input logic [`AXI_ADDR_W-1:0] a,
			input logic [`AXI_ADDR_W-1:0] off);
		reg_hit = (a == off);
	endfunction

	// ***************************************************************
	// pin edges
	// ***************************************************************
	logic             rclk_q;
	logic             wclk_q;
	logic             strobe_q;
	wire logic        r_edge      = read_side_clock_in & ~rclk_q;
	wire logic        w_edge      = write_side_clock_in & ~wclk_q;
	wire logic        strobe_fall = strobe_q & ~define_offset_strobe_in;

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			rclk_q   <= 1'b0;
			wclk_q   <= 1'b0;
			strobe_q <= 1'b0;
		end else begin
			rclk_q   <= read_side_clock_in;
			wclk_q   <= write_side_clock_in;
			strobe_q <= define_offset_strobe_in;
		end
	end

	// ***************************************************************
	// write side
	// ***************************************************************
	logic [`PTR_W-1:0] wr_ptr_q;
	logic [`PTR_W-1:0] rd_ptr_q;
	logic [`PTR_W-1:0] rsync_q;
	logic [1:0]        wrst_cnt_q;
	logic [1:0]        wwake_q;
	logic              in_ready_q;
	wire logic         do_write = w_edge & fifo_reset_n_in & in_ready_q
			& write_enable_a_in & write_enable_b_in;
	wire logic [`PTR_W-1:0] wr_ptr_d = wr_ptr_q + {{(`PTR_W-1){1'b0}}, do_write};
	wire logic         full_d  = ((wr_ptr_d - rsync_q) == `DEPTH);

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			wr_ptr_q   <= '0;
			rsync_q    <= '0;
			wrst_cnt_q <= '0;
			wwake_q    <= '0;
			in_ready_q <= 1'b0;
		end else if (w_edge && !fifo_reset_n_in) begin
			wwake_q <= '0;
			if (wrst_cnt_q != `RST_CNT_MAX) begin
				wrst_cnt_q <= wrst_cnt_q + 2'h1;
			end
			if (wrst_cnt_q == `WR_RESET_EDGE) begin
				wr_ptr_q   <= '0;
				rsync_q    <= '0;
				in_ready_q <= 1'b0;
			end
		end else if (w_edge) begin
			wrst_cnt_q <= '0;
			rsync_q    <= rd_ptr_q;
			wr_ptr_q   <= wr_ptr_d;
			if (wwake_q != `WR_WAKE_DONE) begin
				wwake_q <= wwake_q + 2'h1;
			end
			in_ready_q <= (wwake_q != 2'h0) && !full_d;
		end
	end

	// ***************************************************************
	// read side
	// ***************************************************************
	logic [`PTR_W-1:0]  wsync1_q;
	logic [`PTR_W-1:0]  wsync2_q;
	logic [1:0]         rrst_cnt_q;
	logic               ready_q;
	logic [`DATA_W-1:0] out_q;
	logic [`DATA_W-1:0] mem_rdata;
	wire logic take = read_enable_a_in & read_enable_b_in
			& output_drive_enable_in & ready_q;
	wire logic array_has = (wsync2_q != rd_ptr_q);
	wire logic advance   = r_edge & fifo_reset_n_in & (~ready_q | take);

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			rd_ptr_q   <= '0;
			wsync1_q   <= '0;
			wsync2_q   <= '0;
			rrst_cnt_q <= '0;
			ready_q    <= 1'b0;
			out_q      <= '0;
		end else if (r_edge && !fifo_reset_n_in) begin
			if (rrst_cnt_q != `RST_CNT_MAX) begin
				rrst_cnt_q <= rrst_cnt_q + 2'h1;
			end
			if (rrst_cnt_q == `RD_RESET_EDGE) begin
				rd_ptr_q <= '0;
				wsync1_q <= '0;
				wsync2_q <= '0;
				ready_q  <= 1'b0;
			end
		end else if (r_edge) begin
			rrst_cnt_q <= '0;
			wsync1_q   <= wr_ptr_q;
			wsync2_q   <= wsync1_q;
			if (advance && array_has) begin
				out_q    <= mem_rdata;
				rd_ptr_q <= rd_ptr_q + `LEVEL_ONE;
				ready_q  <= 1'b1;
			end else if (advance) begin
				ready_q  <= 1'b0;
			end
		end
	end

	fifo_store u_store (
		.clock_in    (clock_in),
		.wr_en_in    (do_write),
		.wr_addr_in  (wr_ptr_q[`ADDR_W-1:0]),
		.wr_data_in  (write_data_bus_in),
		.rd_addr_in  (rd_ptr_q[`ADDR_W-1:0]),
		.rd_data_out (mem_rdata)
	);

	// ***************************************************************
	// offset and level flags
	// ***************************************************************
	offset_t stored_q;
	offset_t active_q;
	logic    half_q;
	logic    almost_q;
	wire level_t level_d = (wr_ptr_q - rd_ptr_q) + {{(`PTR_W-1){1'b0}}, ready_q};
	wire level_t act_w   = {2'h0, active_q};
	wire logic near_low  = (level_d <= act_w + `LEVEL_ONE);
	wire logic near_high = (level_d >= `BOUND_HI - act_w);

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			active_q <= `OFF_DEFAULT;
			half_q   <= 1'b0;
			almost_q <= 1'b1;
		end else if (!fifo_reset_n_in) begin
			active_q <= define_offset_strobe_in ? `OFF_DEFAULT : stored_q;
			half_q   <= 1'b0;
			almost_q <= 1'b1;
		end else begin
			half_q   <= (level_d >= `HALF_LEVEL);
			almost_q <= near_low | near_high;
		end
	end

	// ***************************************************************
	// register bus
	// ***************************************************************
	logic                   aw_got_q;
	logic                   w_got_q;
	logic [`AXI_ADDR_W-1:0] awaddr_q;
	offset_reg_s            wdata_q;
	logic [3:0]             wstrb_q;
	logic                   bvalid_q;
	logic [1:0]             bresp_q;
	logic                   rvalid_q;
	logic [1:0]             rresp_q;
	logic [31:0]            rdata_q;
	wire logic aw_take    = s_axi_awvalid_in & s_axi_awready_out;
	wire logic w_take     = s_axi_wvalid_in & s_axi_wready_out;
	wire logic axi_wr_go  = aw_got_q & w_got_q & ~bvalid_q;
	wire logic off_wr_hit = reg_hit(awaddr_q, `REG_OFFSET);
	wire logic ar_take    = s_axi_arvalid_in & s_axi_arready_out;
	wire logic rd_stat    = reg_hit(s_axi_araddr_in, `REG_STATUS);
	wire logic rd_off     = reg_hit(s_axi_araddr_in, `REG_OFFSET);
	status_s     stat_w;
	offset_reg_s off_w;

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			stored_q <= `OFF_DEFAULT;
		end else if (strobe_fall) begin
			stored_q <= write_data_bus_in[`OFF_W-1:0];
		end else if (axi_wr_go && off_wr_hit && (|wstrb_q)) begin
			stored_q <= wdata_q.stored;
		end
	end

	always_comb begin
		stat_w           = '0;
		stat_w.level     = level_d;
		stat_w.out_ready = ready_q;
		stat_w.in_ready  = in_ready_q;
		stat_w.half      = half_q;
		stat_w.almost    = almost_q;
		off_w            = '0;
		off_w.stored     = stored_q;
		off_w.active     = active_q;
	end

	assign s_axi_awready_out = ~aw_got_q & ~bvalid_q;
	assign s_axi_wready_out  = ~w_got_q & ~bvalid_q;
	assign s_axi_arready_out = ~rvalid_q;

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			aw_got_q <= 1'b0;
			w_got_q  <= 1'b0;
			awaddr_q <= '0;
			wdata_q  <= '0;
			wstrb_q  <= '0;
			bvalid_q <= 1'b0;
			bresp_q  <= `RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_got_q <= 1'b1;
				awaddr_q <= s_axi_awaddr_in;
			end
			if (w_take) begin
				w_got_q <= 1'b1;
				wdata_q <= offset_reg_s'(s_axi_wdata_in);
				wstrb_q <= s_axi_wstrb_in;
			end
			if (axi_wr_go) begin
				aw_got_q <= 1'b0;
				w_got_q  <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q  <= (off_wr_hit || reg_hit(awaddr_q, `REG_STATUS))
						? `RESP_OKAY : `RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready_in) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			rvalid_q <= 1'b0;
			rresp_q  <= `RESP_OKAY;
			rdata_q  <= `WORD_ZERO;
		end else if (ar_take) begin
			rvalid_q <= 1'b1;
			rresp_q  <= (rd_stat || rd_off) ? `RESP_OKAY : `RESP_SLVERR;
			rdata_q  <= rd_stat ? 32'(stat_w) : (rd_off ? 32'(off_w) : `WORD_ZERO);
		end else if (rvalid_q && s_axi_rready_in) begin
			rvalid_q <= 1'b0;
		end
	end

	// ***************************************************************
	// outputs
	// ***************************************************************
	assign read_data_bus_out        = out_q;
	assign read_data_bus_oe_out     = output_drive_enable_in;
	assign output_ready_out         = ready_q;
	assign input_ready_out          = in_ready_q;
	assign half_full_flag_out       = half_q;
	assign almost_boundary_flag_out = almost_q;
	assign s_axi_bvalid_out         = bvalid_q;
	assign s_axi_bresp_out          = bresp_q;
	assign s_axi_rvalid_out         = rvalid_q;
	assign s_axi_rresp_out          = rresp_q;
	assign s_axi_rdata_out          = rdata_q;

	// ***************************************************************
	// checks
	// ***************************************************************
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);

	a_ready_means_data: assert property (
		output_ready_out |-> (level_d != 11'h000))
		else $error("output ready with nothing held");
	a_reset_drops_ready: assert property (
		(r_edge && !fifo_reset_n_in && rrst_cnt_q == 2'h2) |=> !output_ready_out)
		else $error("output ready not dropped on third reset edge");
	a_first_word_falls: assert property (
		(r_edge && fifo_reset_n_in && !ready_q && array_has)
		|=> output_ready_out && (read_data_bus_out == $past(mem_rdata)))
		else $error("first word not presented");
	a_last_read_drop: assert property (
		(r_edge && fifo_reset_n_in && take && !array_has) |=> !output_ready_out)
		else $error("output ready held after last read");
	a_word_holds: assert property (
		(ready_q && fifo_reset_n_in && !(r_edge && take))
		|=> $stable(read_data_bus_out) && output_ready_out)
		else $error("output word moved without a read");
	a_write_gated: assert property (
		do_write |-> in_ready_q && write_enable_a_in && write_enable_b_in)
		else $error("word stored without ready and enables");
	a_full_ignores: assert property (
		(w_edge && !in_ready_q) |=> $stable(wr_ptr_q))
		else $error("write pointer moved while not ready");
	a_reset_flags: assert property (
		!fifo_reset_n_in |=> !half_full_flag_out && almost_boundary_flag_out)
		else $error("flags wrong during reset");
	a_half_level: assert property (
		(fifo_reset_n_in && $past(fifo_reset_n_in))
		|-> half_full_flag_out == ($past(level_d) >= 11'h200))
		else $error("half full flag wrong");
	a_default_offset: assert property (
		(!fifo_reset_n_in && define_offset_strobe_in) |=> active_q == 9'h100)
		else $error("default offset not loaded");
	a_offset_capture: assert property (
		strobe_fall |=> stored_q == $past(write_data_bus_in[8:0]))
		else $error("offset not captured on strobe fall");
	a_bus_release: assert property (
		!output_drive_enable_in |-> !read_data_bus_oe_out)
		else $error("data bus driven while disabled");

	c_first_word: cover property (!ready_q ##1 r_edge ##1 output_ready_out);
	c_full: cover property (w_edge && !in_ready_q && fifo_reset_n_in);
	c_drain: cover property (ready_q && r_edge && take && !array_has);
	c_axi_read: cover property (ar_take ##[1:4] s_axi_rvalid_out && s_axi_rready_in);
endmodule

`default_nettype wire

// ===== verilog/fifo_consts.svh
`ifndef FIFO_CONSTS_SVH
`define FIFO_CONSTS_SVH

`define DATA_W        18
`define ADDR_W        10
`define PTR_W         11
`define OFF_W         9
`define DEPTH         11'h400
`define HALF_LEVEL    11'h200
`define BOUND_HI      11'h401
`define LEVEL_ONE     11'h001
`define OFF_DEFAULT   9'h100
`define RST_CNT_MAX   2'h3
`define RD_RESET_EDGE 2'h2
`define WR_RESET_EDGE 2'h1
`define WR_WAKE_DONE  2'h2
`define AXI_ADDR_W    8
`define REG_STATUS    8'h00
`define REG_OFFSET    8'h04
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`define WORD_ZERO     32'h0000_0000

`endif

// ===== verilog/fifo_pkg.sv
`include "fifo_consts.svh"

package fifo_pkg;
	typedef logic [`PTR_W-1:0] level_t;
	typedef logic [`OFF_W-1:0] offset_t;

	// status word seen by software
	typedef struct packed {
		logic [11:0] unused;
		logic        almost;
		logic        half;
		logic        in_ready;
		logic        out_ready;
		logic [4:0]  pad;
		level_t      level;
	} status_s;

	// offset word: stored value is writable, active value read only
	typedef struct packed {
		logic [6:0] pad_hi;
		offset_t    active;
		logic [6:0] pad_lo;
		offset_t    stored;
	} offset_reg_s;
endpackage

// ===== verilog/fifo_store.sv
`timescale 1ns/1ps
`default_nettype none
`include "fifo_consts.svh"

module fifo_store
	import fifo_pkg::*;
(
	input  wire logic                clock_in,
	input  wire logic                wr_en_in,
	input  wire logic [`ADDR_W-1:0]  wr_addr_in,
	input  wire logic [`DATA_W-1:0]  wr_data_in,
	input  wire logic [`ADDR_W-1:0]  rd_addr_in,
	output logic      [`DATA_W-1:0]  rd_data_out
);
	logic [`DATA_W-1:0] mem_q [0:`DEPTH-1];

	// registered read port, one write port
	always_ff @(posedge clock_in) begin
		if (wr_en_in) begin
			mem_q[wr_addr_in] <= wr_data_in;
		end
		rd_data_out <= mem_q[rd_addr_in];
	end
endmodule

`default_nettype wire

// ===== bench/fifo_side_model.sv
`timescale 1ns/1ps
`default_nettype none

module fifo_side_model (
	input  wire logic        clock_in,
	output logic             write_side_clock_out,
	output logic             read_side_clock_out,
	output logic             write_enable_a_out,
	output logic             write_enable_b_out,
	output logic [17:0]      write_data_bus_out,
	output logic             read_enable_a_out,
	output logic             read_enable_b_out,
	output logic             output_drive_enable_out
);
	logic [1:0] wr_cnt_q = 2'h0;
	logic [2:0] rd_cnt_q = 3'h0;

	// ************************
	// free running pin clocks
	// ************************
	always @(posedge clock_in) begin
		wr_cnt_q <= wr_cnt_q + 2'h1;
		rd_cnt_q <= (rd_cnt_q == 3'h5) ? 3'h0 : rd_cnt_q + 3'h1;
	end
	assign write_side_clock_out = wr_cnt_q[1];
	assign read_side_clock_out  = (rd_cnt_q > 3'h2);

	initial begin
		write_enable_a_out = 1'b0;
		write_enable_b_out = 1'b0;
		write_data_bus_out = 18'h0_0000;
		read_enable_a_out = 1'b0;
		read_enable_b_out = 1'b0;
		output_drive_enable_out = 1'b1;
	end

	// ************************
	// writer and reader steps
	// ************************
	task automatic drive(input logic [17:0] d, input logic a, input logic b);
		@(posedge clock_in);
		write_data_bus_out <= d;
		write_enable_a_out <= a;
		write_enable_b_out <= b;
	endtask

	task automatic write_word(input logic [17:0] d, input logic a, input logic b);
		@(negedge write_side_clock_out);
		write_data_bus_out <= d;
		write_enable_a_out <= a;
		write_enable_b_out <= b;
		@(posedge write_side_clock_out);
		@(posedge clock_in);
		write_data_bus_out <= ~d;
		write_enable_a_out <= 1'b0;
		write_enable_b_out <= 1'b0;
	endtask

	task automatic read_step(input logic a, input logic b, input logic oe);
		@(negedge read_side_clock_out);
		read_enable_a_out <= a;
		read_enable_b_out <= b;
		output_drive_enable_out <= oe;
		@(posedge read_side_clock_out);
		@(posedge clock_in);
		read_enable_a_out <= 1'b0;
		read_enable_b_out <= 1'b0;
	endtask
endmodule

`default_nettype wire

// ===== bench/dual_clock_flagged_fifo_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "fifo_consts.svh"

module dual_clock_flagged_fifo_bench
	import fifo_pkg::*;
;
	logic clock_in, rst_n_in, fifo_reset_n_in, define_offset_strobe_in;
	logic write_side_clock_in, write_enable_a_in, write_enable_b_in, read_side_clock_in;
	logic read_enable_a_in, read_enable_b_in, output_drive_enable_in;
	logic [`DATA_W-1:0] write_data_bus_in, read_data_bus_out;
	logic read_data_bus_oe_out, output_ready_out, input_ready_out;
	logic half_full_flag_out, almost_boundary_flag_out;
	logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
	logic [31:0] s_axi_wdata_in, s_axi_rdata_out, x, d;
	logic [3:0] s_axi_wstrb_in;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out, r;
	logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out;
	logic s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
	logic s_axi_rvalid_out, s_axi_rready_in;
	logic [17:0] q[$];
	int off = 256;
	int seed = 32'hd6c4_d326;
	int num_errors = 0;
	int samples_checked = 0;

	flagged_fifo dut_u (
		.clock_in, .rst_n_in, .fifo_reset_n_in, .define_offset_strobe_in,
		.write_side_clock_in, .write_enable_a_in, .write_enable_b_in, .write_data_bus_in,
		.read_side_clock_in, .read_enable_a_in, .read_enable_b_in, .output_drive_enable_in,
		.read_data_bus_out, .read_data_bus_oe_out, .output_ready_out, .input_ready_out,
		.half_full_flag_out, .almost_boundary_flag_out,
		.s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in,
		.s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
		.s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in,
		.s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
		.s_axi_rready_in
	);

	fifo_side_model pm_u (
		.clock_in,
		.write_side_clock_out(write_side_clock_in),
		.read_side_clock_out(read_side_clock_in),
		.write_enable_a_out(write_enable_a_in),
		.write_enable_b_out(write_enable_b_in),
		.write_data_bus_out(write_data_bus_in),
		.read_enable_a_out(read_enable_a_in),
		.read_enable_b_out(read_enable_b_in),
		.output_drive_enable_out(output_drive_enable_in)
	);

	// ************************
	// compare and report
	// ************************
	task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_pin(input logic [17:0] got, input logic [17:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t pin %h expected %h", $time, got, exp);
		end
	endtask

	task automatic final_report;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	function automatic logic [31:0] exp_status();
		int n;
		n = q.size();
		exp_status = {12'h000, (n <= off + 1 || n >= 1025 - off), (n >= 512), (n < 1025),
			(n > 0), 5'h00, n[10:0]};
	endfunction

	// ************************
	// register bus master
	// ************************
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
		@(posedge clock_in);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'b1;
		s_axi_rready_in <= 1'b1;
		forever begin
			@(posedge clock_in);
			if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
			if (s_axi_rvalid_out) begin
				v = s_axi_rdata_out;
				e = s_axi_rresp_out;
				s_axi_rready_in <= 1'b0;
				break;
			end
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] e);
		@(posedge clock_in);
		s_axi_awaddr_in <= a;
		s_axi_awvalid_in <= 1'b1;
		s_axi_wdata_in <= v;
		s_axi_wvalid_in <= 1'b1;
		s_axi_bready_in <= 1'b1;
		forever begin
			@(posedge clock_in);
			if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
			if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
			if (s_axi_bvalid_out) begin
				e = s_axi_bresp_out;
				s_axi_bready_in <= 1'b0;
				break;
			end
		end
	endtask

	task automatic check_status(input logic [31:0] mask);
		logic [31:0] v;
		logic [1:0] e;
		axi_rd(`REG_STATUS, v, e);
		check_reg(v & mask, exp_status() & mask);
	endtask

	// ************************
	// buffer sequences
	// ************************
	task automatic settle;
		repeat (4) @(posedge read_side_clock_in);
		repeat (3) @(posedge clock_in);
		#1;
	endtask

	task automatic fifo_reset(input logic s);
		@(posedge clock_in);
		define_offset_strobe_in <= s;
		fifo_reset_n_in <= 1'b0;
		repeat (60) @(posedge clock_in);
		#1;
		check_pin(output_ready_out, 1'b0);
		check_pin(input_ready_out, 1'b0);
		check_pin(half_full_flag_out, 1'b0);
		check_pin(almost_boundary_flag_out, 1'b1);
		@(posedge clock_in);
		fifo_reset_n_in <= 1'b1;
		repeat (40) @(posedge clock_in);
		q.delete();
	endtask

	task automatic first_word;
		@(posedge read_side_clock_in);
		repeat (2) @(posedge clock_in);
		check_pin(output_ready_out, 1'b0);
		settle;
		check_pin(read_data_bus_out, q[0]);
		check_pin(output_ready_out, 1'b1);
	endtask

	initial begin
		clock_in = 1'b0;
		forever #12.5 clock_in = ~clock_in;
	end

	initial begin
		#2_000_000;
		num_errors++;
		final_report;
	end

	initial begin
		{rst_n_in, fifo_reset_n_in, define_offset_strobe_in} = 3'h3;
		{s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = 48'h0000_0000_0000;
		{s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 3'h0;
		{s_axi_arvalid_in, s_axi_rready_in} = 2'h0;
		s_axi_wstrb_in = 4'hf;
		repeat (8) @(posedge clock_in);
		rst_n_in <= 1'b1;
		fifo_reset(1'b1);
		axi_rd(`REG_OFFSET, d, r);
		check_reg(d, 32'h0100_0100);
		axi_rd(8'h08, d, r);
		check_reg({d[29:0], r}, {30'h0000_0000, `RESP_SLVERR});
		axi_wr(`REG_STATUS, 32'hffff_ffff, r);
		check_reg(32'(r), 32'(`RESP_OKAY));
		x = $random(seed);
		off = x[8:0];
		pm_u.drive(x[17:0], 1'b1, 1'b1);
		repeat (3) @(posedge clock_in);
		define_offset_strobe_in <= 1'b0;
		repeat (3) @(posedge clock_in);
		pm_u.drive(~x[17:0], 1'b0, 1'b0);
		fifo_reset(1'b0);
		axi_rd(`REG_OFFSET, d, r);
		check_reg(d, {7'h00, x[8:0], 7'h00, x[8:0]});
		for (int i = 0; i < 1100; i++) begin
			d = $random(seed);
			if (i >= 40) d[19:18] = 2'b11;
			pm_u.write_word(d[17:0], d[18], d[19]);
			if (d[19:18] == 2'b11 && q.size() < 1025) begin
				q.push_back(d[17:0]);
				if (q.size() == 1) first_word();
			end
			check_status(32'hffff_ffff);
		end
		for (int k = 0; k < 3; k++) begin
			pm_u.read_step(k != 0, k != 1, k != 2);
			@(posedge clock_in);
			#1;
			check_pin(read_data_bus_out, q[0]);
			check_pin(read_data_bus_oe_out, k != 2);
		end
		check_status(32'hffff_ffff);
		while (q.size() > 0) begin
			pm_u.read_step(1'b1, 1'b1, 1'b1);
			void'(q.pop_front());
			@(posedge clock_in);
			#1;
			if (q.size() > 0) check_pin(read_data_bus_out, q[0]);
			check_pin(output_ready_out, q.size() > 0);
			check_status(32'hfffd_ffff);
			if (q.size() == 1024) begin
				settle;
				check_pin(input_ready_out, 1'b1);
			end
		end
		repeat (3) pm_u.write_word(18'h2_5a5a, 1'b1, 1'b1);
		fifo_reset(1'b1);
		off = 256;
		check_status(32'hffff_ffff);
		axi_rd(`REG_OFFSET, d, r);
		check_reg(d, {7'h00, 9'h100, 7'h00, x[8:0]});
		axi_wr(`REG_OFFSET, {16'h0000, 7'h00, x[24:16]}, r);
		check_reg(32'(r), 32'(`RESP_OKAY));
		axi_rd(`REG_OFFSET, d, r);
		check_reg(d, {7'h00, 9'h100, 7'h00, x[24:16]});
		final_report;
	end
endmodule

`default_nettype wire
